// ===== logic/oscctl_pkg.sv
package oscctl_pkg;

  // Register addresses in the special-function register space.
  localparam logic [7:0] LF_CTRL_ADDR  = 8'h86;
  localparam logic [7:0] EXT_CTRL_ADDR = 8'hb1;

  // Field positions of the low-frequency control register.
  localparam int LF_EN_BIT    = 7;
  localparam int LF_RDY_BIT   = 6;
  localparam int LF_TRIM_LSB  = 2;
  localparam int LF_DIV_LSB   = 0;

  // Field positions of the external control register.
  localparam int EXT_VLD_BIT  = 7;
  localparam int EXT_MODE_LSB = 4;
  localparam int EXT_FCN_LSB  = 0;

  // Reset values; the trim value is normally a factory setting.
  localparam logic       LF_EN_RESET   = 1'b0;
  localparam logic [3:0] LF_TRIM_RESET = 4'h0;
  localparam logic [1:0] LF_DIV_RESET  = 2'h0;
  localparam logic [2:0] EXT_MODE_RESET = 3'h0;
  localparam logic [2:0] EXT_FCN_RESET  = 3'h0;

  // Divider select codes shared by both clock paths.
  localparam logic [1:0] DIV_BY8 = 2'h0;
  localparam logic [1:0] DIV_BY4 = 2'h1;
  localparam logic [1:0] DIV_BY2 = 2'h2;
  localparam logic [1:0] DIV_BY1 = 2'h3;

  // External oscillator mode codes.
  localparam logic [2:0] MODE_CMOS     = 3'h2;
  localparam logic [2:0] MODE_CMOS_DIV = 3'h3;
  localparam logic [2:0] MODE_RC       = 3'h4;
  localparam logic [2:0] MODE_CAP      = 3'h5;
  localparam logic [2:0] MODE_XTAL     = 3'h6;
  localparam logic [2:0] MODE_XTAL_DIV = 3'h7;

  // Timing: oscillator edges needed for settling, and the silence that voids the valid flag.
  localparam logic [5:0] LF_SETTLE_EDGES  = 6'h20;
  localparam logic [6:0] EXT_VALID_EDGES  = 7'h40;
  localparam int         CLK_PERIOD_NS    = 20;
  localparam int         EXT_STALL_NS     = 20000;
  localparam logic [10:0] EXT_STALL_CYCLES = 11'(EXT_STALL_NS / CLK_PERIOD_NS);

  // Low-frequency control fields as stored.
  typedef struct packed {
    logic       enable;
    logic [3:0] trim;
    logic [1:0] div;
  } oscctl_lf_s;

  // External control fields as stored.
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] fcn;
  } oscctl_ext_s;

  // One-hot states of the external valid detector.
  typedef enum logic [2:0] {
    EV_IDLE  = 3'b001,
    EV_COUNT = 3'b010,
    EV_GOOD  = 3'b100
  } oscctl_ev_e;

endpackage : oscctl_pkg

// ===== logic/oscctl_clkdiv.sv
`timescale 1ns/1ps
// Synchronises a raw oscillator level and divides it by 8, 4, 2 or 1.
module oscctl_clkdiv (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       osc_i,
  input  wire logic       en_i,
  input  wire logic [1:0] sel_i,
  output logic            rise_o,
  output logic            out_o
);

  logic       sync1;  // First stage, read only by the second.
  logic       sync2;  // Second stage, safe to use.
  logic       sync3;  // Previous level for edge detection.
  logic [1:0] cnt;    // Rising edges since the last toggle.
  logic [1:0] lim;    // Edges per half output period, minus one.

  // Two-flop synchroniser plus one delay stage for the edge detector.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= osc_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise_o = en_i & sync2 & ~sync3;

  // Half period in edges: 4 for divide by 8, down to 1 for divide by 2.
  always_comb begin
    unique case (sel_i)
      oscctl_pkg::DIV_BY8: lim = 2'h3;
      oscctl_pkg::DIV_BY4: lim = 2'h1;
      default:             lim = 2'h0;
    endcase
  end

  // Toggle stage; in the dividing codes every toggle sits on a rising edge, so the duty cycle is 50%; divide by 1 passes sync2 through.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt   <= 2'h0;
      out_o <= 1'b0;
    end else if (!en_i) begin
      cnt   <= 2'h0;
      out_o <= 1'b0;
    end else if (sel_i == oscctl_pkg::DIV_BY1) begin
      cnt   <= 2'h0;
      out_o <= sync2;
    end else if (rise_o) begin
      if (cnt == lim) begin
        cnt   <= 2'h0;
        out_o <= ~out_o;
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end

  a_div_halve: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && sel_i == oscctl_pkg::DIV_BY2 && rise_o |=> out_o != $past(out_o))
    else $error("Halving stage missed a toggle.");

endmodule : oscctl_clkdiv

// ===== logic/oscctl_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Low-frequency oscillator runs only while enabled.
// - Read-only ready flag shows settled oscillator.
// - Ready clears only on reset or divider change.
// - Four-bit trim: zero fastest, all ones slowest.
// - Divider codes select divide by 8,4,2,1.
// - Crystal takes two port pins, other running modes one.
// - External clock offered to system and peripherals.
// - Halving modes give 50% duty external clock.
// - Valid detector reports running, stable external clock.
// - Mode field decodes off, CMOS, RC, capacitor, crystal.
// - Valid reads zero in both CMOS modes.
module oscctl_top (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       SFR_WE_I,
  input  wire logic       SFR_RE_I,
  input  wire logic       LF_OSC_I,
  input  wire logic       EXT_OSC_I,
  output logic      [7:0] SFR_RDATA_O,
  output logic            LF_OSC_RUN_O,
  output logic      [3:0] LF_TRIM_O,
  output logic            LF_CLK_O,
  output logic      [2:0] EXT_MODE_O,
  output logic      [2:0] EXT_FREQ_CTRL_O,
  output logic            EXT_CLK_O,
  output logic            EXT_CLK_AVAIL_O,
  output logic            PORT0_BIT2_TAKE_O,
  output logic            PORT0_BIT3_TAKE_O
);

  oscctl_pkg::oscctl_lf_s  lf_ctrl;       // Low-frequency control fields.
  oscctl_pkg::oscctl_ext_s ext_ctrl;      // External control fields.
  oscctl_pkg::oscctl_ev_e  ev_state;      // Valid detector state.
  logic                    lf_ready;      // Sticky ready flag.
  logic              [5:0] settle_cnt;    // Oscillator edges seen while settling.
  logic                    lf_rise;       // One cycle per synchronised oscillator edge.
  logic                    ext_rise;      // One cycle per external clock edge.
  logic                    ext_clk;       // Divided external clock.
  logic              [6:0] edge_cnt;      // Edges counted toward validity.
  logic             [10:0] stall_cnt;     // Cycles since the last external edge.
  logic                    lf_wr;         // Write strobe to the low-frequency register.
  logic                    ext_wr;        // Write strobe to the external register.
  logic                    div_change;    // Software changes the divider field.
  logic                    mode_change;   // Software changes the mode field.
  logic                    ext_on;        // Mode field selects a running circuit.
  logic                    ext_cmos;      // Mode field selects a CMOS clock input.
  logic                    ext_xtal;      // Mode field selects crystal or resonator.
  logic                    ext_half;      // Mode field selects a halving stage.
  logic                    ext_valid;     // Detector reports a stable clock.
  logic                    stalled;       // No external edge for too long.

  // Address decode of the two registers.
  assign lf_wr       = SFR_WE_I && SFR_ADDR_I == oscctl_pkg::LF_CTRL_ADDR;
  assign ext_wr      = SFR_WE_I && SFR_ADDR_I == oscctl_pkg::EXT_CTRL_ADDR;
  assign div_change  = lf_wr && SFR_WDATA_I[oscctl_pkg::LF_DIV_LSB +: 2] != lf_ctrl.div;
  assign mode_change = ext_wr && SFR_WDATA_I[oscctl_pkg::EXT_MODE_LSB +: 3] != ext_ctrl.mode;

  // Mode decode; 00x is off, bit 0 marks the halving stage in CMOS and crystal.
  assign ext_on    = ext_ctrl.mode[2:1] != 2'h0;
  assign ext_cmos  = ext_ctrl.mode == oscctl_pkg::MODE_CMOS ||
                     ext_ctrl.mode == oscctl_pkg::MODE_CMOS_DIV;
  assign ext_xtal  = ext_ctrl.mode == oscctl_pkg::MODE_XTAL ||
                     ext_ctrl.mode == oscctl_pkg::MODE_XTAL_DIV;
  assign ext_half  = ext_ctrl.mode == oscctl_pkg::MODE_CMOS_DIV ||
                     ext_ctrl.mode == oscctl_pkg::MODE_XTAL_DIV;
  assign ext_valid = ev_state == oscctl_pkg::EV_GOOD;
  assign stalled   = stall_cnt == oscctl_pkg::EXT_STALL_CYCLES;

  // Low-frequency register writes; the ready bit ignores writes.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lf_ctrl.enable <= oscctl_pkg::LF_EN_RESET;
      lf_ctrl.trim   <= oscctl_pkg::LF_TRIM_RESET;
      lf_ctrl.div    <= oscctl_pkg::LF_DIV_RESET;
    end else if (lf_wr) begin
      lf_ctrl.enable <= SFR_WDATA_I[oscctl_pkg::LF_EN_BIT];
      lf_ctrl.trim   <= SFR_WDATA_I[oscctl_pkg::LF_TRIM_LSB +: 4];
      lf_ctrl.div    <= SFR_WDATA_I[oscctl_pkg::LF_DIV_LSB +: 2];
    end
  end

  // External register writes; bit 3 and the valid bit are read-only.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ext_ctrl.mode <= oscctl_pkg::EXT_MODE_RESET;
      ext_ctrl.fcn  <= oscctl_pkg::EXT_FCN_RESET;
    end else if (ext_wr) begin
      ext_ctrl.mode <= SFR_WDATA_I[oscctl_pkg::EXT_MODE_LSB +: 3];
      ext_ctrl.fcn  <= SFR_WDATA_I[oscctl_pkg::EXT_FCN_LSB +: 3];
    end
  end

  // Read data is registered; the divider field is write-only and reads zero.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SFR_RDATA_O <= 8'h00;
    end else if (SFR_RE_I) begin
      unique case (SFR_ADDR_I)
        oscctl_pkg::LF_CTRL_ADDR:
          SFR_RDATA_O <= {lf_ctrl.enable, lf_ready, lf_ctrl.trim, 2'h0};
        oscctl_pkg::EXT_CTRL_ADDR:
          SFR_RDATA_O <= {ext_valid, ext_ctrl.mode, 1'b0, ext_ctrl.fcn};
        default:
          SFR_RDATA_O <= 8'h00;
      endcase
    end
  end

  // Low-frequency clock path; the divider stops with the oscillator.
  oscctl_clkdiv u_lf_div (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .osc_i  (LF_OSC_I),
    .en_i   (lf_ctrl.enable),
    .sel_i  (lf_ctrl.div),
    .rise_o (lf_rise),
    .out_o  (LF_CLK_O)
  );

  // Ready flag counts oscillator edges. A divider change wins over a
  // coinciding set, since the old settling no longer counts.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lf_ready   <= 1'b0;
      settle_cnt <= 6'h00;
    end else if (div_change) begin
      lf_ready   <= 1'b0;
      settle_cnt <= 6'h00;
    end else if (!lf_ready && lf_rise) begin
      if (settle_cnt == oscctl_pkg::LF_SETTLE_EDGES - 6'h01) begin
        lf_ready <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 6'h01;
      end
    end
  end

  // Analog drive of the low-frequency oscillator.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      LF_OSC_RUN_O <= 1'b0;
      LF_TRIM_O    <= oscctl_pkg::LF_TRIM_RESET;
    end else begin
      LF_OSC_RUN_O <= lf_ctrl.enable;
      LF_TRIM_O    <= lf_ctrl.trim;
    end
  end

  // External clock path; halving modes divide by two for a 50% duty cycle.
  oscctl_clkdiv u_ext_div (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .osc_i  (EXT_OSC_I),
    .en_i   (ext_on),
    .sel_i  (ext_half ? oscctl_pkg::DIV_BY2 : oscctl_pkg::DIV_BY1),
    .rise_o (ext_rise),
    .out_o  (ext_clk)
  );

  // Silence timer: any rising edge restarts it, it saturates at the stall limit.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stall_cnt <= 11'h000;
    end else if (ext_rise || ev_state == oscctl_pkg::EV_IDLE) begin
      stall_cnt <= 11'h000;
    end else if (!stalled) begin
      stall_cnt <= stall_cnt + 11'h001;
    end
  end

  // Valid detector. CMOS inputs are never qualified, so the flag stays low there.
  // A crystal that stops for the stall time loses its valid status again.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ev_state <= oscctl_pkg::EV_IDLE;
      edge_cnt <= 7'h00;
    end else if (mode_change || !ext_on || ext_cmos) begin
      ev_state <= oscctl_pkg::EV_IDLE;
      edge_cnt <= 7'h00;
    end else begin
      unique case (ev_state)
        oscctl_pkg::EV_IDLE: begin
          ev_state <= oscctl_pkg::EV_COUNT;
          edge_cnt <= 7'h00;
        end
        oscctl_pkg::EV_COUNT: begin
          if (stalled) begin
            edge_cnt <= 7'h00;
          end else if (ext_rise) begin
            if (edge_cnt == oscctl_pkg::EXT_VALID_EDGES - 7'h01) begin
              ev_state <= oscctl_pkg::EV_GOOD;
            end else begin
              edge_cnt <= edge_cnt + 7'h01;
            end
          end
        end
        oscctl_pkg::EV_GOOD: begin
          if (stalled) begin
            ev_state <= oscctl_pkg::EV_COUNT;
            edge_cnt <= 7'h00;
          end
        end
        default: begin
          ev_state <= oscctl_pkg::EV_IDLE;
          edge_cnt <= 7'h00;
        end
      endcase
    end
  end

  // Pin take-over, analog settings and the clock offered downstream.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PORT0_BIT2_TAKE_O <= 1'b0;
      PORT0_BIT3_TAKE_O <= 1'b0;
      EXT_MODE_O        <= oscctl_pkg::EXT_MODE_RESET;
      EXT_FREQ_CTRL_O   <= oscctl_pkg::EXT_FCN_RESET;
      EXT_CLK_O         <= 1'b0;
      EXT_CLK_AVAIL_O   <= 1'b0;
    end else begin
      PORT0_BIT2_TAKE_O <= ext_xtal;
      PORT0_BIT3_TAKE_O <= ext_on;
      EXT_MODE_O        <= ext_ctrl.mode;
      EXT_FREQ_CTRL_O   <= ext_ctrl.fcn;
      EXT_CLK_O         <= ext_clk;
      EXT_CLK_AVAIL_O   <= ext_on && (ext_cmos || ext_valid);
    end
  end

  a_ready_sticky: assert property (@(posedge CLK_I) disable iff (RST_I)
    lf_ready && !div_change |=> lf_ready)
    else $error("Ready flag dropped without a divider change.");

  a_ready_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
    div_change |=> !lf_ready && settle_cnt == 6'h00)
    else $error("Divider change did not restart settling.");

  a_ready_rise: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(lf_ready) |-> $past(lf_rise) &&
      $past(settle_cnt) == oscctl_pkg::LF_SETTLE_EDGES - 6'h01)
    else $error("Ready flag set before the settling count.");

  a_lf_stops: assert property (@(posedge CLK_I) disable iff (RST_I)
    !lf_ctrl.enable |=> !LF_CLK_O && !LF_OSC_RUN_O)
    else $error("Low-frequency clock runs while disabled.");

  a_xtal_pins: assert property (@(posedge CLK_I) disable iff (RST_I)
    ext_xtal |=> PORT0_BIT2_TAKE_O && PORT0_BIT3_TAKE_O)
    else $error("Crystal mode did not take both pins.");

  a_single_pin: assert property (@(posedge CLK_I) disable iff (RST_I)
    ext_on && !ext_xtal |=> !PORT0_BIT2_TAKE_O && PORT0_BIT3_TAKE_O)
    else $error("Non-crystal mode pin take-over wrong.");

  a_cmos_invalid: assert property (@(posedge CLK_I) disable iff (RST_I)
    ext_cmos |=> !ext_valid)
    else $error("Valid flag set in a CMOS mode.");

  a_valid_edges: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(ext_valid) |-> $past(ext_rise) &&
      $past(edge_cnt) == oscctl_pkg::EXT_VALID_EDGES - 7'h01)
    else $error("External clock declared valid too early.");

  a_mode_off: assert property (@(posedge CLK_I) disable iff (RST_I)
    !ext_on |=> !PORT0_BIT3_TAKE_O && !EXT_CLK_AVAIL_O ##1 !EXT_CLK_O)
    else $error("External circuit active while off.");

endmodule : oscctl_top

// ===== bench/oscctl_osc_model.sv
`timescale 1ns/1ps
// Stand-in for the two oscillators: the internal low-frequency cell and an external source.
module oscctl_osc_model #(
  parameter int LF_HALF_NS  = 100,
  parameter int EXT_HALF_NS = 60
) (
  input  wire logic lf_run_i,
  input  wire logic ext_run_i,
  output logic      lf_osc_o,
  output logic      ext_osc_o
);
  // The cell oscillates only while the run enable is high and rests low otherwise.
  // The enable changes on a clock edge, so the cell starts one step later.
  // This keeps every pin change off the edge and clear of a race with the synchroniser.
  always begin
    if (lf_run_i) begin
      #(LF_HALF_NS) lf_osc_o = ~lf_osc_o;
    end else begin
      lf_osc_o = 1'b0;
      @(lf_run_i);
      #1;
    end
  end

  // A stopped crystal leaves its pin quiet, which lets the bench test the stall timeout.
  always begin
    if (ext_run_i) begin
      #(EXT_HALF_NS) ext_osc_o = ~ext_osc_o;
    end else begin
      ext_osc_o = 1'b0;
      @(ext_run_i);
    end
  end
endmodule : oscctl_osc_model

// ===== bench/tb_osc_lowfreq_and_ext_control.sv
`timescale 1ns/1ps
// Self-checking bench for the oscillator control block.
module tb_osc_lowfreq_and_ext_control;
  logic       clk, rst, we, re, ext_run;  // Bench-driven controls.
  logic [7:0] addr, wdata, rd, v1, v2;    // Bus fields and scratch results.
  logic [7:0] rdata;                      // Register read data.
  logic       lf_osc, ext_osc, lf_run, lf_clk, ext_clk, avail, take2, take3;
  logic [3:0] trim;                       // Trim to the oscillator cell.
  logic [2:0] mode, fctl;                 // External mode and frequency fields.
  int         error_cnt, n_checks;        // Mismatch and comparison counters.

  oscctl_top oscctl_top_inst (.CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata),
    .SFR_WE_I(we), .SFR_RE_I(re), .LF_OSC_I(lf_osc), .EXT_OSC_I(ext_osc), .SFR_RDATA_O(rdata),
    .LF_OSC_RUN_O(lf_run), .LF_TRIM_O(trim), .LF_CLK_O(lf_clk), .EXT_MODE_O(mode),
    .EXT_FREQ_CTRL_O(fctl), .EXT_CLK_O(ext_clk), .EXT_CLK_AVAIL_O(avail),
    .PORT0_BIT2_TAKE_O(take2), .PORT0_BIT3_TAKE_O(take3));

  // The source reaches only a pin that the block has claimed. Firmware keeps that pin off the
  // crossbar and in the matching input mode, so nothing else drives it.
  oscctl_osc_model oscctl_osc_model_inst (.lf_run_i(lf_run),
    .ext_run_i(ext_run && take3),
    .lf_osc_o(lf_osc), .ext_osc_o(ext_osc));

  // Free-running 50 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compares one result and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Waits n edges and steps off the edge so settled values are seen.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // One write pulse, then two edges so the registered copies have landed.
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
    cyc(2);
  endtask : sfr_wr

  // One read pulse; the answer holds, so it is taken an edge later.
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    re = 1'b1;
    cyc(1);
    re = 1'b0;
    cyc(1);
    d = rdata;
  endtask : sfr_rd

  // Counts oscillator rises between two rises of the divided clock.
  task automatic lf_count(output logic [7:0] n);
    logic po, pc;
    int   k;
    po = lf_osc;
    pc = lf_clk;
    n = 8'h00;
    k = 0;
    repeat (3000) begin
      cyc(1);
      if (lf_osc && !po && k == 1) n++;
      if (lf_clk && !pc) k++;
      po = lf_osc;
      pc = lf_clk;
      if (k == 2) break;
    end
  endtask : lf_count

  // Measures period and high time of the external clock in system cycles.
  task automatic ext_meas(output logic [7:0] per, output logic [7:0] hi);
    logic pc;
    int   k;
    pc = ext_clk;
    per = 8'h00;
    hi = 8'h00;
    k = 0;
    repeat (3000) begin
      cyc(1);
      if (ext_clk && !pc) k++;
      if (k == 1) per++;
      if (k == 1 && ext_clk) hi++;
      pc = ext_clk;
      if (k == 2) break;
    end
  endtask : ext_meas

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Reset values and an unmapped address.
  task automatic t_reset;
    sfr_rd(8'h86, rd);
    chk(rd, 8'h00);
    sfr_rd(8'hb1, rd);
    chk(rd, 8'h00);
    sfr_rd(8'h55, rd);
    chk(rd, 8'h00);
  endtask : t_reset

  // Enable, settle, then walk every divider code; each change except the one back to divide by 8 is checked to drop ready for a while.
  task automatic t_lowfreq;
    sfr_wr(8'h86, 8'hbf);
    chk(8'(lf_run), 8'h01);
    chk(8'(trim), 8'h0f);
    sfr_rd(8'h86, rd);
    chk(rd, 8'hbc);
    cyc(450);
    sfr_rd(8'h86, rd);
    chk(rd, 8'hfc);
    sfr_wr(8'h86, 8'hbc); // Back to divide by 8 clears ready again.
    cyc(450);
    lf_count(v1);
    chk(v1, 8'h08);
    for (int d = 1; d < 4; d++) begin
      sfr_wr(8'h86, 8'h80 | 8'(d << 2) | 8'(d));
      chk(8'(trim), 8'(d));
      sfr_rd(8'h86, rd);
      chk(rd, 8'h80 | 8'(d << 2));
      cyc(100);
      sfr_rd(8'h86, rd);
      chk(rd, 8'h80 | 8'(d << 2));
      cyc(350);
      sfr_rd(8'h86, rd);
      chk(rd, 8'hc0 | 8'(d << 2));
      lf_count(v1);
      chk(v1, 8'h08 >> d);
    end
    sfr_wr(8'h86, 8'h83); // Same divider code: ready must survive.
    sfr_rd(8'h86, rd);
    chk(rd, 8'hc0);
    sfr_wr(8'h86, 8'h03); // Disable stops the cell but leaves ready set.
    chk(8'(lf_run), 8'h00);
    cyc(20);
    chk(8'(lf_clk), 8'h00);
    sfr_rd(8'h86, rd);
    chk(rd, 8'h40);
  endtask : t_lowfreq

  // Reset in mid-run: the ready flag that survived the disable must now drop.
  task automatic t_rerst;
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    chk(8'(lf_run), 8'h00);
    sfr_rd(8'h86, rd);
    chk(rd, 8'h00);
  endtask : t_rerst

  // Every mode code: field copies, pin take-over, unused bit reads zero.
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      sfr_wr(8'hb1, 8'(m << 4) | 8'h08 | 8'(7 - m));
      chk(8'(mode), 8'(m));
      chk(8'(fctl), 8'(7 - m));
      chk(8'(take2), 8'(m >= 6));
      chk(8'(take3), 8'(m >= 2));
      sfr_rd(8'hb1, rd);
      chk(rd, 8'(m << 4) | 8'(7 - m));
    end
  endtask : t_modes

  // Crystal start-up the way firmware does it, halving stage, CMOS modes and the stall timeout.
  task automatic t_valid;
    int n;
    ext_run = 1'b1;
    sfr_wr(8'hb1, 8'h63);
    cyc(50000);
    rd = 8'h00;
    // Poll the valid flag before anything relies on the crystal; a bounded poll cannot hang.
    for (n = 0; n < 16 && !rd[7]; n++) begin
      sfr_rd(8'hb1, rd);
    end
    chk(rd, 8'he3);
    chk(8'(avail), 8'h01);
    ext_meas(v1, v2);
    chk(v1, 8'h06);
    sfr_wr(8'hb1, 8'h73);
    sfr_rd(8'hb1, rd);
    chk(rd, 8'h73);
    cyc(500);
    ext_meas(v1, v2);
    chk(v1, 8'h0c);
    chk(v2, 8'h06);
    sfr_wr(8'hb1, 8'h23);
    cyc(500);
    sfr_rd(8'hb1, rd);
    chk(rd, 8'h23);
    chk(8'(avail), 8'h01);
    sfr_wr(8'hb1, 8'h33);
    ext_meas(v1, v2);
    chk(v1, 8'h0c);
    chk(v2, 8'h06);
    sfr_wr(8'hb1, 8'h63);
    cyc(500);
    sfr_rd(8'hb1, rd);
    chk(rd, 8'he3);
    ext_run = 1'b0; // A stalled crystal must void the flag.
    cyc(1100);
    sfr_rd(8'hb1, rd);
    chk(rd, 8'h63);
    chk(8'(avail), 8'h00);
  endtask : t_valid

  // Main sequence: three cycles of reset, then the scenarios.
  initial begin
    error_cnt = 0;
    n_checks = 0;
    rst = 1'b1;
    we = 1'b0;
    re = 1'b0;
    ext_run = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    cyc(3);
    rst = 1'b0;
    t_reset();
    t_lowfreq();
    t_rerst();
    t_modes();
    t_valid();
    wrap_up();
  end

  // The scenarios take about 1.1 ms, mostly the crystal start-up wait; 1.6 ms means a hang.
  initial begin
    #1600000;
    error_cnt++;
    wrap_up();
  end
endmodule : tb_osc_lowfreq_and_ext_control
